// ===== rtl/nested_interrupt_controller_pkg.sv
// Purpose : shared constants of the nested interrupt controller
// Assumes : one system clock, active-low asynchronous reset
// Notes   : priorities keep only their upper bits; lower field bits read as zero
//
// How it works
// - on acceptance the controller fetches the handler address from the vector table itself
// - the vector table base sits at address zero and cannot move
// - table word zero gives the main stack pointer, fetched right after reset
// - handler entry for an exception sits at the word indexed by its vector number
// - enable bits: write one to set port sets, to clear port clears, zeros ignored
// - set-enable and clear-enable reads both return the present enable bits
// - a request on a disabled line pends it but never activates it
// - disabling an active line keeps it active until exception return or reset
// - pending bits: write ones to set or clear, zeros have no effect
// - set-pending and clear-pending reads both return the present pending bits
// - clearing pending never touches the active state of a line
// - each priority is an 8-bit field, four fields per 32-bit word
// - all controller registers form one mapped set reached through the register ports
// - 32 external request lines, four priority levels, plus one non-maskable line
// - each external line may be level sensitive or pulse sensitive; the non-maskable line is always pulse sensitive

package nested_interrupt_controller_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_IRQ         = 32;   // external request lines
   localparam int PRIO_BITS       = 2;    // implemented priority bits, four levels
   localparam int PRIO_FIELD_W    = 8;    // width of one priority field
   localparam int FIELDS_PER_WORD = 4;    // priority fields in one word
   localparam int WORD_W          = 32;
   localparam int IDX_W           = 5;    // line number width
   localparam int VEC_W           = 8;    // vector number width
   localparam int PWORD_IDX_W     = 3;    // priority word index width

   // ----------------------------------------------------------------
   // vector table
   // ----------------------------------------------------------------
   localparam logic [31:0]      VECTOR_TABLE_BASE = 32'h0000_0000;
   localparam logic [VEC_W-1:0] MSP_WORD          = 8'h00;
   localparam logic [VEC_W-1:0] NMI_VECTOR        = 8'h02;
   localparam logic [VEC_W-1:0] EXT_VECTOR_FIRST  = 8'h10;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic                 ENABLE_RESET  = 1'h0;
   localparam logic                 PENDING_RESET = 1'h0;
   localparam logic                 ACTIVE_RESET  = 1'h0;
   localparam logic [PRIO_BITS-1:0] PRIO_RESET    = 2'h0;

endpackage

// ===== rtl/irq_request_sense.sv
// Purpose : synchronise request lines and turn them into pend requests
// Assumes : lines are asynchronous to clk_sys
// Notes   : pulse mode pends on a rising edge, level mode while high
`timescale 1ns/1ns

module irq_request_sense #(
   parameter int N = 33
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   // request lines and their mode
   input  wire logic [N-1:0] line,
   input  wire logic [N-1:0] pulse_mode,
   // pend requests
   output logic      [N-1:0] sensed
);

   logic [N-1:0] sync1;
   logic [N-1:0] sync2;
   logic [N-1:0] prev;
   logic [N-1:0] next_prev;

   // edge history follows the second stage only
   always_comb begin
      next_prev = sync2;
   end

   // two-stage synchroniser plus edge history
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync1 <= '0;
         sync2 <= '0;
         prev  <= '0;
      end else begin
         sync1 <= line;
         sync2 <= sync1;
         prev  <= next_prev;
      end
   end

   // level or rising edge per line
   assign sensed = (pulse_mode & sync2 & ~prev) | (~pulse_mode & sync2);

endmodule

// ===== rtl/nested_interrupt_controller.sv
// Purpose : nested vectored interrupt controller for the processor core
// Assumes : core and vector memory run on clk_sys; request lines are asynchronous
// Notes   : lower priority value is more urgent; nmi beats every line
`timescale 1ns/1ns

module nested_interrupt_controller #(
   parameter int NUM_IRQ   = nested_interrupt_controller_pkg::NUM_IRQ,
   parameter int PRIO_BITS = nested_interrupt_controller_pkg::PRIO_BITS
) (
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rstn,
   // request lines
   input  wire logic [NUM_IRQ-1:0]  irq_line,
   input  wire logic                nmi_line,
   input  wire logic [NUM_IRQ-1:0]  sense_pulse,
   // register writes
   input  wire logic                set_enable_wr,
   input  wire logic                clear_enable_wr,
   input  wire logic                set_pending_wr,
   input  wire logic                clear_pending_wr,
   input  wire logic [NUM_IRQ-1:0]  wdata,
   input  wire logic                prio_wr,
   input  wire logic [2:0]          prio_widx,
   input  wire logic [31:0]         prio_wdata,
   input  wire logic [2:0]          prio_ridx,
   // register reads
   output logic      [NUM_IRQ-1:0]  enable_state,
   output logic      [NUM_IRQ-1:0]  pending_state,
   output logic      [NUM_IRQ-1:0]  active_state,
   output logic      [31:0]         prio_rdata,
   output logic                     nmi_pending,
   output logic                     nmi_active,
   // core side
   output logic                     irq_req,
   output logic      [7:0]          irq_vector,
   input  wire logic                irq_ack,
   input  wire logic                exc_return,
   input  wire logic [7:0]          exc_vector,
   output logic      [31:0]         handler_addr,
   output logic                     handler_valid,
   output logic      [31:0]         main_stack_pointer,
   output logic                     msp_valid,
   // vector table read port
   output logic                     vec_rd,
   output logic      [31:0]         vec_addr,
   input  wire logic [31:0]         vec_rdata,
   input  wire logic                vec_valid
);

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   localparam int IDX_W = nested_interrupt_controller_pkg::IDX_W;
   localparam int PF_W  = nested_interrupt_controller_pkg::PRIO_FIELD_W;
   localparam int FPW   = nested_interrupt_controller_pkg::FIELDS_PER_WORD;
   localparam int PICK_W = 1 + PRIO_BITS + IDX_W;

   // widths beyond the index and field sizes cannot be served
   initial begin
      if (NUM_IRQ < FPW || NUM_IRQ > 32 || (NUM_IRQ % FPW) != 0)
         $error("NUM_IRQ must be a multiple of four up to 32");
      if (PRIO_BITS < 1 || PRIO_BITS > PF_W)
         $error("PRIO_BITS must be 1 to 8");
   end

   typedef enum logic [1:0] {BOOT_FETCH, IDLE, VEC_FETCH} ctrl_state_t;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // byte address of a table word
   function automatic logic [31:0] table_addr(input logic [7:0] vec);
      table_addr = nested_interrupt_controller_pkg::VECTOR_TABLE_BASE
                   + {22'h000000, vec, 2'b00};
   endfunction

   // most urgent set bit of mask: {found, prio, index}
   function automatic logic [PICK_W-1:0] best_pick(
      input logic [NUM_IRQ-1:0]           mask,
      input logic [NUM_IRQ*PRIO_BITS-1:0] pf
   );
      logic                 found;
      logic [PRIO_BITS-1:0] bp;
      logic [IDX_W-1:0]     bi;
      found = 1'b0;
      bp    = '0;
      bi    = '0;
      // descending scan with <= leaves the lowest number on ties
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (mask[i] && (!found || pf[i*PRIO_BITS +: PRIO_BITS] <= bp)) begin
            found = 1'b1;
            bp    = pf[i*PRIO_BITS +: PRIO_BITS];
            bi    = IDX_W'(i);
         end
      end
      best_pick = {found, bp, bi};
   endfunction

   // ----------------------------------------------------------------
   // request sensing
   // ----------------------------------------------------------------
   logic [NUM_IRQ:0] sensed_all;
   logic [NUM_IRQ-1:0] sensed;
   logic               nmi_sensed;

   irq_request_sense #(
      .N (NUM_IRQ + 1)
   ) u_sense (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .line       ({nmi_line, irq_line}),
      .pulse_mode ({1'b1, sense_pulse}),
      .sensed     (sensed_all)
   );

   assign sensed     = sensed_all[NUM_IRQ-1:0];
   assign nmi_sensed = sensed_all[NUM_IRQ];

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   logic [PRIO_BITS-1:0]       prio [NUM_IRQ];
   logic [NUM_IRQ*PRIO_BITS-1:0] prio_flat;
   ctrl_state_t                state, next_state;
   logic                       offer_nmi, next_offer_nmi;
   logic [IDX_W-1:0]           offer_idx, next_offer_idx;
   logic                       req_reg, next_req_reg;
   logic [7:0]                 cur_vec, next_cur_vec;
   logic [NUM_IRQ-1:0]         next_enable, next_pending, next_active;
   logic                       next_nmi_pending, next_nmi_active;
   logic [31:0]                next_handler_addr, next_msp, next_prio_rdata;
   logic                       next_handler_valid, next_msp_valid;
   logic [7:0]                 next_irq_vector;

   always_comb begin
      for (int i = 0; i < NUM_IRQ; i++) begin
         prio_flat[i*PRIO_BITS +: PRIO_BITS] = prio[i];
      end
   end

   // ----------------------------------------------------------------
   // arbitration
   // ----------------------------------------------------------------
   logic [PICK_W-1:0]  cand, run;
   logic               cand_ok, offer_valid, accept;
   logic [NUM_IRQ-1:0] acc_mask, ret_mask;

   // candidate among enabled, pending, inactive lines; running level among active
   assign cand = best_pick(pending_state & enable_state & ~active_state, prio_flat);
   assign run  = best_pick(active_state, prio_flat);
   // nested preemption needs a strictly more urgent level
   assign cand_ok = cand[PICK_W-1] && !nmi_active
                    && (!run[PICK_W-1]
                        || cand[IDX_W +: PRIO_BITS] < run[IDX_W +: PRIO_BITS]);

   // the offer is withdrawn as soon as its line loses enable or pending
   assign offer_valid = offer_nmi ? (nmi_pending && !nmi_active)
                        : (pending_state[offer_idx] && enable_state[offer_idx]
                           && !active_state[offer_idx]);
   assign irq_req  = req_reg && offer_valid && (state == IDLE);
   assign accept   = irq_req && irq_ack;
   assign acc_mask = (accept && !offer_nmi) ? (NUM_IRQ'(1) << offer_idx) : '0;

   // exception return retires one line
   always_comb begin
      ret_mask = '0;
      if (exc_return && exc_vector >= nested_interrupt_controller_pkg::EXT_VECTOR_FIRST
          && exc_vector < nested_interrupt_controller_pkg::EXT_VECTOR_FIRST + 8'(NUM_IRQ))
         ret_mask = NUM_IRQ'(1) << (exc_vector
                    - nested_interrupt_controller_pkg::EXT_VECTOR_FIRST);
   end

   // ----------------------------------------------------------------
   // per-line enable, pending, active
   // ----------------------------------------------------------------
   always_comb begin
      next_enable = enable_state;
      if (clear_enable_wr)
         next_enable = next_enable & ~wdata;
      if (set_enable_wr)
         next_enable = next_enable | wdata;
      // acceptance and software clear drop a bit; any set wins the same cycle
      next_pending = (pending_state & ~(clear_pending_wr ? wdata : '0) & ~acc_mask)
                     | sensed | (set_pending_wr ? wdata : '0);
      // only acceptance sets and only return clears active
      next_active = (active_state & ~ret_mask) | acc_mask;
      next_nmi_pending = (nmi_pending && !(accept && offer_nmi)) || nmi_sensed;
      next_nmi_active  = (nmi_active && !(exc_return
                          && exc_vector == nested_interrupt_controller_pkg::NMI_VECTOR))
                         || (accept && offer_nmi);
   end

   // enable, pending and active registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         enable_state  <= {NUM_IRQ{nested_interrupt_controller_pkg::ENABLE_RESET}};
         pending_state <= {NUM_IRQ{nested_interrupt_controller_pkg::PENDING_RESET}};
         active_state  <= {NUM_IRQ{nested_interrupt_controller_pkg::ACTIVE_RESET}};
         nmi_pending   <= nested_interrupt_controller_pkg::PENDING_RESET;
         nmi_active    <= nested_interrupt_controller_pkg::ACTIVE_RESET;
      end else begin
         enable_state  <= next_enable;
         pending_state <= next_pending;
         active_state  <= next_active;
         nmi_pending   <= next_nmi_pending;
         nmi_active    <= next_nmi_active;
      end
   end

   // ----------------------------------------------------------------
   // priority fields
   // ----------------------------------------------------------------

   // readback of one word, unimplemented low field bits as zero
   always_comb begin
      next_prio_rdata = '0;
      for (int b = 0; b < FPW; b++) begin
         if (int'(prio_ridx) * FPW + b < NUM_IRQ)
            next_prio_rdata[b*PF_W + PF_W - PRIO_BITS +: PRIO_BITS] =
               prio[int'(prio_ridx) * FPW + b];
      end
   end

   // field write keeps the upper bits of each byte
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_IRQ; i++) begin
            prio[i] <= nested_interrupt_controller_pkg::PRIO_RESET;
         end
         prio_rdata <= '0;
      end else begin
         prio_rdata <= next_prio_rdata;
         if (prio_wr) begin
            for (int b = 0; b < FPW; b++) begin
               if (int'(prio_widx) * FPW + b < NUM_IRQ)
                  prio[int'(prio_widx) * FPW + b] <=
                     prio_wdata[b*PF_W + PF_W - PRIO_BITS +: PRIO_BITS];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // control sequence: boot fetch, offer, vector fetch
   // ----------------------------------------------------------------
   always_comb begin
      next_state         = state;
      next_offer_nmi     = offer_nmi;
      next_offer_idx     = offer_idx;
      next_req_reg       = 1'b0;
      next_cur_vec       = cur_vec;
      next_handler_addr  = handler_addr;
      next_handler_valid = 1'b0;
      next_msp           = main_stack_pointer;
      next_msp_valid     = msp_valid;
      next_irq_vector    = irq_vector;
      unique case (state)
         BOOT_FETCH: begin
            if (vec_valid) begin
               next_msp       = vec_rdata;
               next_msp_valid = 1'b1;
               next_state     = IDLE;
            end
         end
         IDLE: begin
            if (accept) begin
               next_cur_vec = irq_vector;
               next_state   = VEC_FETCH;
            end else begin
               // refresh the offer every cycle, nmi first
               next_req_reg   = (nmi_pending && !nmi_active) || cand_ok;
               next_offer_nmi = nmi_pending && !nmi_active;
               next_offer_idx = cand[IDX_W-1:0];
               next_irq_vector = next_offer_nmi ? nested_interrupt_controller_pkg::NMI_VECTOR
                                 : nested_interrupt_controller_pkg::EXT_VECTOR_FIRST
                                   + 8'(cand[IDX_W-1:0]);
            end
         end
         VEC_FETCH: begin
            if (vec_valid) begin
               next_handler_addr  = vec_rdata;
               next_handler_valid = 1'b1;
               next_state         = IDLE;
            end
         end
      endcase
   end

   // table read port follows the state
   assign vec_rd   = (state == BOOT_FETCH) || (state == VEC_FETCH);
   assign vec_addr = (state == BOOT_FETCH)
                     ? table_addr(nested_interrupt_controller_pkg::MSP_WORD)
                     : table_addr(cur_vec);

   // control registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state              <= BOOT_FETCH;
         offer_nmi          <= 1'b0;
         offer_idx          <= '0;
         req_reg            <= 1'b0;
         cur_vec            <= '0;
         handler_addr       <= '0;
         handler_valid      <= 1'b0;
         main_stack_pointer <= '0;
         msp_valid          <= 1'b0;
         irq_vector         <= '0;
      end else begin
         state              <= next_state;
         offer_nmi          <= next_offer_nmi;
         offer_idx          <= next_offer_idx;
         req_reg            <= next_req_reg;
         cur_vec            <= next_cur_vec;
         handler_addr       <= next_handler_addr;
         handler_valid      <= next_handler_valid;
         main_stack_pointer <= next_msp;
         msp_valid          <= next_msp_valid;
         irq_vector         <= next_irq_vector;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   boot_word_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (vec_rd && !msp_valid) |-> vec_addr == 32'h0000_0000)
      else $error("boot fetch not at table word zero");

   fetch_index_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      accept |=> vec_rd && vec_addr == {22'h000000, $past(irq_vector), 2'b00})
      else $error("vector fetch address does not match accepted vector");

   handler_load_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (vec_rd && vec_valid && msp_valid)
      |=> handler_valid && handler_addr == $past(vec_rdata) ##1 !handler_valid)
      else $error("handler address not delivered for one cycle");

   no_disabled_act_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (active_state & ~$past(active_state)
       & ~($past(enable_state) & $past(pending_state))) == '0)
      else $error("line activated while disabled or not pending");

   active_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !exc_return |=> ($past(active_state) & ~active_state) == '0)
      else $error("active state lost without exception return");

   enable_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (set_enable_wr && !clear_enable_wr) |=> (enable_state & $past(wdata)) == $past(wdata))
      else $error("set-enable write did not set bits");

   pend_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clear_pending_wr && !set_pending_wr)
      |=> (pending_state & $past(wdata) & ~$past(sensed)) == '0)
      else $error("clear-pending write left bits set");

   msp_first_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      irq_req |-> msp_valid)
      else $error("interrupt offered before stack pointer load");

endmodule

// ===== testbench/core_memory_model.sv
// Purpose : processor core and vector memory facing the controller
// Assumes : answers on clk_sys; wait_cycles zero gives a same-cycle answer
// Notes   : read data shows the inverted word while no answer is given
`timescale 1ns/1ns

module core_memory_model #(
   parameter logic [31:0] STACK_TOP = 32'h2000_1000
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // behaviour controls
   input  wire logic        ack_en,
   input  wire logic [1:0]  wait_cycles,
   // core side
   input  wire logic        irq_req,
   output logic             irq_ack,
   // vector table port
   input  wire logic        vec_rd,
   input  wire logic [31:0] vec_addr,
   output logic [31:0]      vec_rdata,
   output logic             vec_valid
);
   logic [1:0]  waited;
   logic [31:0] word;

   // table at zero: stack top in word zero, else a handler tagged by its address
   assign word      = (vec_addr == 32'h0000_0000) ? STACK_TOP : (32'hC000_0000 | vec_addr);
   assign vec_valid = vec_rd && (waited == wait_cycles);
   assign vec_rdata = vec_valid ? word : ~word;
   assign irq_ack   = ack_en && irq_req;

   // stall counter for slow answers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         waited <= 2'h0;
      else if (!vec_rd || vec_valid)
         waited <= 2'h0;
      else
         waited <= waited + 2'h1;
   end
endmodule

// ===== testbench/tb_nested_interrupt_controller.sv
// Purpose : self-checking bench of the nested interrupt controller
// Assumes : inputs change on the falling edge of clk_sys
// Notes   : wr_s bits are set enable, clear enable, set pending, clear pending
`timescale 1ns/1ns

module tb_nested_interrupt_controller;
   localparam logic [31:0] MSP_VAL = 32'h2000_1000;
   logic        clk_sys = 1'b0, rstn = 1'b0, nmi_line = 1'b0, prio_wr = 1'b0;
   logic        exc_return = 1'b0, ack_en = 1'b0;
   logic [3:0]  wr_s = 4'h0;
   logic [1:0]  wait_cycles = 2'h0;
   logic [2:0]  prio_widx = 3'h0, prio_ridx = 3'h0;
   logic [7:0]  exc_vector = 8'h00, irq_vector;
   logic [31:0] irq_line = '0, sense_pulse = '0, wdata = '0, prio_wdata = '0;
   logic [31:0] enable_state, pending_state, active_state, prio_rdata;
   logic [31:0] handler_addr, main_stack_pointer, vec_addr, vec_rdata;
   logic        nmi_pending, nmi_active, irq_req, irq_ack, handler_valid;
   logic        msp_valid, vec_rd, vec_valid;
   int          fails = 0, comparisons = 0, n;

   always #20 clk_sys = ~clk_sys;

   nested_interrupt_controller i_dut (.clk_sys(clk_sys), .rstn(rstn), .irq_line(irq_line),
      .nmi_line(nmi_line), .sense_pulse(sense_pulse), .set_enable_wr(wr_s[0]),
      .clear_enable_wr(wr_s[1]), .set_pending_wr(wr_s[2]), .clear_pending_wr(wr_s[3]),
      .wdata(wdata), .prio_wr(prio_wr), .prio_widx(prio_widx), .prio_wdata(prio_wdata),
      .prio_ridx(prio_ridx), .enable_state(enable_state), .pending_state(pending_state),
      .active_state(active_state), .prio_rdata(prio_rdata), .nmi_pending(nmi_pending),
      .nmi_active(nmi_active), .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
      .exc_return(exc_return), .exc_vector(exc_vector), .handler_addr(handler_addr),
      .handler_valid(handler_valid), .main_stack_pointer(main_stack_pointer),
      .msp_valid(msp_valid), .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_rdata(vec_rdata),
      .vec_valid(vec_valid));

   core_memory_model #(.STACK_TOP(MSP_VAL)) i_core (.clk_sys(clk_sys), .rstn(rstn),
      .ack_en(ack_en), .wait_cycles(wait_cycles), .irq_req(irq_req), .irq_ack(irq_ack),
      .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_rdata(vec_rdata), .vec_valid(vec_valid));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one-cycle write strobe k with data d
   task automatic wr(input int k, input logic [31:0] d);
      @(negedge clk_sys);
      wr_s[k] = 1'b1;
      wdata = d;
      @(negedge clk_sys);
      wr_s = 4'h0;
   endtask

   task automatic ret(input logic [7:0] v);
      @(negedge clk_sys);
      exc_return = 1'b1;
      exc_vector = v;
      @(negedge clk_sys);
      exc_return = 1'b0;
   endtask

   // accept the standing offer and check the fetched handler address
   task automatic take(input logic [31:0] exp);
      ack_en = 1'b1;
      for (n = 0; n < 30 && handler_valid !== 1'b1; n++) @(negedge clk_sys);
      ack_en = 1'b0;
      chk("handler_valid", 32'h1, {31'h0, handler_valid});
      chk("handler", exp, handler_addr);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_boot;
      chk("enable", 32'h0, enable_state);
      chk("pending", 32'h0, pending_state | active_state);
      chk("prio", 32'h0, prio_rdata);
      for (n = 0; n < 20 && msp_valid !== 1'b1; n++) @(negedge clk_sys);
      chk("msp", MSP_VAL, main_stack_pointer);
      chk("msp_valid", 32'h1, {31'h0, msp_valid});
      $display("test boot done");
   endtask

   task automatic t_bits;
      wr(0, 32'hF0F0_000F);
      chk("enable", 32'hF0F0_000F, enable_state);
      wr(1, 32'h0000_0003);
      wr(0, 32'h0);
      chk("enable", 32'hF0F0_000C, enable_state);
      wr(1, 32'hFFFF_FFFF);
      wr(2, 32'h8000_0300);
      chk("pending", 32'h8000_0300, pending_state);
      wr(3, 32'h0000_0100);
      wr(3, 32'h0);
      chk("pending", 32'h8000_0200, pending_state);
      chk("active", 32'h0, active_state);
      wr(3, 32'hFFFF_FFFF);
      chk("enable", 32'h0, enable_state | pending_state);
      $display("test bits done");
   endtask

   task automatic t_lines;
      irq_line[5] = 1'b1;
      sense_pulse[7] = 1'b1;
      irq_line[7] = 1'b1;
      repeat (5) @(negedge clk_sys);
      chk("pending", 32'h0000_00A0, pending_state);
      chk("offer", 32'h0, {31'h0, irq_req} | active_state);
      irq_line[5] = 1'b0;
      repeat (4) @(negedge clk_sys);
      wr(3, 32'h0000_00A0);
      repeat (3) @(negedge clk_sys);
      chk("pending", 32'h0, pending_state);
      irq_line[7] = 1'b0;
      $display("test lines done");
   endtask

   task automatic t_accept;
      @(negedge clk_sys);
      prio_wr = 1'b1;
      prio_widx = 3'h2;
      prio_wdata = 32'hFFC0_8041;
      prio_ridx = 3'h2;
      @(negedge clk_sys);
      prio_wr = 1'b0;
      @(negedge clk_sys);
      chk("prio", 32'hC0C0_8040, prio_rdata);
      wait_cycles = 2'h2;
      wr(0, 32'h0000_0E00);
      wr(2, 32'h0000_0C00);
      for (n = 0; n < 10 && irq_req !== 1'b1; n++) @(negedge clk_sys);
      chk("vector", 32'h11A, {23'h0, irq_req, irq_vector});
      take(32'hC000_0068);
      chk("active", 32'h0000_0400, active_state);
      wr(2, 32'h0000_0200);
      for (n = 0; n < 10 && irq_req !== 1'b1; n++) @(negedge clk_sys);
      chk("vector", 32'h119, {23'h0, irq_req, irq_vector});
      wr(1, 32'h0000_0600);
      wr(3, 32'h0000_0600);
      chk("active", 32'h0000_0400, active_state);
      ret(8'h1A);
      chk("active", 32'h0, active_state);
      $display("test accept done");
   endtask

   task automatic t_nmi;
      wr(1, 32'hFFFF_FFFF);
      wr(3, 32'hFFFF_FFFF);
      wait_cycles = 2'h0;
      nmi_line = 1'b1;
      take(32'hC000_0008);
      chk("nmi", 32'h1, {30'h0, nmi_pending, nmi_active});
      ret(8'h02);
      chk("nmi", 32'h0, {30'h0, nmi_pending, nmi_active});
      nmi_line = 1'b0;
      $display("test nmi done");
   endtask

   initial begin
      repeat (4) @(negedge clk_sys);
      rstn = 1'b1;
      @(negedge clk_sys);
      t_boot;
      t_bits;
      t_lines;
      t_accept;
      t_nmi;
      report_and_stop;
   end

   // watchdog well beyond the expected run
   initial begin
      #(40 * 3000);
      fails++;
      report_and_stop;
   end
endmodule
